// [rtl/fmac_pkg.sv]
// fmac_pkg: constants and types of the flash plane and mode access control
// assumes a 20 MHz system clock and a 32-bit APB register port
package fmac_pkg;
  localparam int ADDR_W = 19;
  localparam int PADDR_W = 8;
  localparam int BAUD_W = 16;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PLANE = 8'h04;
  localparam logic [7:0] OFS_KEY = 8'h08;
  localparam logic [7:0] OFS_CODE = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_BAUD = 8'h14;
  // field positions
  localparam int CTRL_PGM_EN_BIT = 0;
  localparam int CTRL_VEC_DONE_BIT = 1;
  localparam int CODE_DL_BIT = 0;
  localparam int CODE_FWE_BIT = 1;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_PHASE_LSB = 4;
  localparam int STAT_SETTLE_BIT = 8;
  // reset values and key values
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [7:0] KEY_PROG = 8'ha5;
  localparam logic [7:0] KEY_DL = 8'h5a;
  // plane geometry and erase block layout
  localparam logic [ADDR_W-1:0] UB_SIZE = 19'h02000;
  localparam logic [ADDR_W-1:0] SMALL_END = 19'h08000;
  localparam logic [ADDR_W-1:0] MID_END = 19'h10000;
  localparam logic [3:0] BLK_MID = 4'h8;
  // mode pin codes sampled at reset
  localparam logic [2:0] MP_ROM_OFF = 3'h0;
  localparam logic [2:0] MP_BOOT = 3'h1;
  localparam logic [2:0] MP_USER_BOOT = 3'h2;
  localparam logic [2:0] MP_PROM = 3'h3;
  // access kinds
  localparam logic [1:0] KIND_READ = 2'h0;
  localparam logic [1:0] KIND_PROG = 2'h1;
  localparam logic [1:0] KIND_ERASE_BLK = 2'h2;
  localparam logic [1:0] KIND_ERASE_ALL = 2'h3;
  // vector fetch sources
  localparam logic [1:0] VEC_USER = 2'h0;
  localparam logic [1:0] VEC_UBOOT = 2'h1;
  localparam logic [1:0] VEC_EMB = 2'h2;
  localparam logic [1:0] VEC_NONE = 2'h3;
  // timing
  localparam int CLK_MHZ = 20;
  localparam int SETTLE_US = 100;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int SETTLE_W = 12;
  localparam int BAUD_BITS = 9;
  typedef enum logic [2:0] {
    FM_ROM_OFF = 3'h0, FM_USER = 3'h1, FM_USER_PROG = 3'h3,
    FM_USER_BOOT = 3'h2, FM_BOOT = 3'h6, FM_PROM = 3'h7
  } fmac_mode_t;
  typedef enum logic [1:0] {
    PH_STRAP = 2'b00, PH_VECTOR = 2'b01, PH_RUN = 2'b11, PH_ERASE = 2'b10
  } fmac_phase_t;
  typedef enum logic [1:0] {
    AB_IDLE = 2'b00, AB_COUNT = 2'b01, AB_LOCK = 2'b11
  } fmac_baud_t;
endpackage

// [rtl/fmac_sync.sv]
// fmac_sync: two-flop synchroniser for pins from outside the clock domain
// assumes the pins are quasi-static levels; no reset so straps pass in reset
`timescale 1ns/10ps
`default_nettype none
module fmac_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  initial begin
    if (W < 1) $error("fmac_sync width must be at least 1");
  end
  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule
`default_nettype wire

// [rtl/fmac_decode.sv]
// fmac_decode: address to erase block number and user boot range check
// assumes a 19-bit byte address into the user plane
`timescale 1ns/10ps
`default_nettype none
module fmac_decode
  import fmac_pkg::*;
(
  input wire logic [fmac_pkg::ADDR_W-1:0] addr,
  output logic [3:0] blk,
  output logic ub_over
);
  import fmac_pkg::*;
  // ascending blocks: eight small, one middle, seven large
  function automatic logic [3:0] blk_of(input logic [ADDR_W-1:0] a);
    logic [3:0] b;
    b = 4'h0;
    if (a < SMALL_END) begin
      b = {1'b0, a[14:12]};
    end else if (a < MID_END) begin
      b = BLK_MID;
    end else begin
      b = BLK_MID + {1'b0, a[18:16]};
    end
    return b;
  endfunction
  // block layout and plane bound
  always_comb begin
    blk = blk_of(addr); // [RULE11] [RULE21]
    ub_over = (addr >= UB_SIZE); // [RULE10]
  end
endmodule
`default_nettype wire

// [rtl/fmac_top.sv]
// fmac_top: flash plane and operating mode access control with APB registers
// assumes APB master and flash access requester on REF_CLK, pins asynchronous
`timescale 1ns/10ps
`default_nettype none
// Function
// RULE1: sample mode pins and write-enable pin in reset, enter mode on release
// RULE2: ROM-invalid mode blocks all flash reads, programs and erases
// RULE3: user mode allows reads, rejects programming and erasing
// RULE4: on-board program and erase only in user program, user boot, boot modes
// RULE5: programmer mode reads, programs, erases both planes; erase is whole only
// RULE6: both planes share start address; plane select register steers accesses
// RULE7: power-on start from user plane in user mode, boot plane in user boot
// RULE8: user boot reset fetches embedded vector first, boot plane vector after check
// RULE9: boot plane programming only in boot mode and programmer mode
// RULE10: boot plane addresses past 8 kbytes read back undefined
// RULE11: user plane erases in 16 blocks: seven 64k, one 32k, eight 4k
// RULE12: boot mode auto-erases both planes; no reads or block erase before
// RULE13: agent programs each 128-byte unit once, only when fully erased
// RULE14: leaving boot or user boot mode needs mode change and reset
// RULE15: program enable bit toggles user and user program mode without reset
// RULE16: boot mode takes serial data and matches the host bit rate
// RULE17: software protection by key register, hardware by write-enable pin
// RULE18: on-chip routines in RAM program and erase via interface registers
// RULE19: download request bit with key register starts routine download
// RULE20: software sets program enable bit before programming or erasing
// RULE21: erase block numbers ascend from plane start address
module fmac_top
  import fmac_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [fmac_pkg::PADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [2:0] MODE_PINS,
  input wire logic FWE_PIN,
  input wire logic RXD,
  input wire logic ACC_REQ,
  input wire logic [1:0] ACC_KIND,
  input wire logic [fmac_pkg::ADDR_W-1:0] ACC_ADDR,
  output logic ACC_DONE,
  output logic ACC_OK,
  output logic ACC_UNDEF,
  output logic ACC_PLANE,
  output logic [3:0] ACC_BLOCK,
  output logic [1:0] VEC_SRC,
  output logic AUTO_ERASE_REQ,
  input wire logic AUTO_ERASE_DONE,
  output logic DL_REQ,
  input wire logic DL_DONE,
  output logic [fmac_pkg::BAUD_W-1:0] BAUD_DIV,
  output logic [2:0] MODE_STATE
);
  import fmac_pkg::*;

  logic [4:0] pins_s;
  logic fwe_s, rxd_s;
  logic started, next_started;
  fmac_mode_t mode, next_mode;
  fmac_phase_t phase, next_phase;
  logic pgm_en, next_pgm_en;
  logic plane_sel, next_plane_sel;
  logic [7:0] key, next_key;
  logic dl, next_dl;
  logic [SETTLE_W-1:0] settle, next_settle;
  logic [1:0] next_vec;
  logic next_aer;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic wr_go, rd_setup, vec_done_wr;
  logic [3:0] blk;
  logic ub_over;
  logic next_done, next_ok, next_undef;
  logic pe_base, onboard;
  fmac_baud_t ab, next_ab;
  logic [BAUD_W-1:0] ab_cnt, next_ab_cnt, next_baud;
  logic rxd_d, next_rxd_d;

  initial begin
    if (SETTLE_CYC >= (1 << SETTLE_W)) $error("settle count too wide");
  end

  fmac_sync #(.W(5)) u_sync (
    .clk(REF_CLK),
    .d({RXD, FWE_PIN, MODE_PINS}),
    .q(pins_s)
  );
  assign fwe_s = pins_s[3];
  assign rxd_s = pins_s[4];

  fmac_decode u_dec (
    .addr(ACC_ADDR),
    .blk(blk),
    .ub_over(ub_over)
  );

  // APB decode: answer in the access phase's first edge
  always_comb begin
    rd_setup = PSEL && !PENABLE;
    wr_go = PSEL && PENABLE && PREADY && PWRITE;
    vec_done_wr = wr_go && (PADDR == OFS_CTRL) && PWDATA[CTRL_VEC_DONE_BIT];
    next_pready = rd_setup;
    next_pslverr = 1'b0;
    next_prdata = 32'h0;
    next_pgm_en = pgm_en;
    next_plane_sel = plane_sel;
    next_key = key;
    next_dl = dl;
    if (rd_setup) begin
      unique case (PADDR)
        OFS_CTRL: next_prdata[CTRL_PGM_EN_BIT] = pgm_en;
        OFS_PLANE: next_prdata[0] = plane_sel;
        OFS_KEY: next_prdata[7:0] = key;
        OFS_CODE: begin
          next_prdata[CODE_DL_BIT] = dl;
          next_prdata[CODE_FWE_BIT] = fwe_s; // [RULE17]
        end
        OFS_STATUS: begin
          next_prdata[STAT_MODE_LSB +: 3] = mode;
          next_prdata[STAT_PHASE_LSB +: 2] = phase;
          next_prdata[STAT_SETTLE_BIT] = (settle != '0);
        end
        OFS_BAUD: next_prdata[BAUD_W-1:0] = BAUD_DIV;
        default: next_pslverr = 1'b1;
      endcase
    end
    if (wr_go) begin
      unique case (PADDR)
        OFS_CTRL: next_pgm_en = PWDATA[CTRL_PGM_EN_BIT]; // [RULE15]
        OFS_PLANE: next_plane_sel = PWDATA[0]; // [RULE6]
        OFS_KEY: next_key = PWDATA[7:0]; // [RULE17]
        default: ;
      endcase
    end
    // completion clears, a new request in the same cycle wins
    if (DL_DONE) next_dl = 1'b0;
    if (wr_go && (PADDR == OFS_CODE) && PWDATA[CODE_DL_BIT] && (key == KEY_DL)) begin
      next_dl = 1'b1; // [RULE19] [RULE18]
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA <= 32'h0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      pgm_en <= 1'b0;
      plane_sel <= 1'b0;
      key <= KEY_RESET;
      dl <= 1'b0;
    end else begin
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
      pgm_en <= next_pgm_en;
      plane_sel <= next_plane_sel;
      key <= next_key;
      dl <= next_dl;
    end
  end
  assign DL_REQ = dl;

  // mode capture after release, boot sequencing, settle wait
  always_comb begin
    next_started = 1'b1;
    next_mode = mode;
    next_phase = phase;
    next_settle = settle;
    if (settle != '0) next_settle = settle - 1'b1;
    if (!started) begin
      unique case (pins_s[2:0]) // [RULE1]
        MP_ROM_OFF: next_mode = FM_ROM_OFF;
        MP_BOOT: next_mode = pins_s[3] ? FM_BOOT : FM_USER;
        MP_USER_BOOT: next_mode = pins_s[3] ? FM_USER_BOOT : FM_USER;
        MP_PROM: next_mode = FM_PROM;
        default: next_mode = FM_USER;
      endcase
    end else begin
      // only user and user program interchange; others hold until reset
      if (mode == FM_USER && pgm_en) next_mode = FM_USER_PROG; // [RULE15] [RULE14]
      if (mode == FM_USER_PROG && !pgm_en) begin
        next_mode = FM_USER; // [RULE15]
        next_settle = SETTLE_CYC[SETTLE_W-1:0];
      end
    end
    unique case (phase)
      PH_STRAP: begin
        if (started) begin
          if (mode == FM_BOOT) next_phase = PH_ERASE; // [RULE12]
          else if (mode == FM_USER_BOOT) next_phase = PH_VECTOR; // [RULE8]
          else next_phase = PH_RUN;
        end
      end
      PH_VECTOR: if (vec_done_wr) next_phase = PH_RUN; // [RULE8]
      PH_ERASE: if (AUTO_ERASE_DONE) next_phase = PH_RUN; // [RULE12]
      PH_RUN: ;
    endcase
    next_aer = (next_phase == PH_ERASE); // [RULE12]
    if (next_mode == FM_ROM_OFF || !started) next_vec = VEC_NONE;
    else if (next_mode == FM_BOOT || next_phase == PH_VECTOR) next_vec = VEC_EMB; // [RULE8]
    else if (next_mode == FM_USER_BOOT) next_vec = VEC_UBOOT; // [RULE7]
    else next_vec = VEC_USER; // [RULE7]
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      started <= 1'b0;
      mode <= FM_ROM_OFF;
      phase <= PH_STRAP;
      settle <= '0;
      VEC_SRC <= VEC_NONE;
      AUTO_ERASE_REQ <= 1'b0;
    end else begin
      started <= next_started;
      mode <= next_mode;
      phase <= next_phase;
      settle <= next_settle;
      VEC_SRC <= next_vec;
      AUTO_ERASE_REQ <= next_aer;
    end
  end
  assign MODE_STATE = mode;

  // access check, answered one edge after the request
  always_comb begin
    onboard = (mode == FM_USER_PROG) || (mode == FM_USER_BOOT) || (mode == FM_BOOT); // [RULE4]
    pe_base = fwe_s && (phase == PH_RUN) &&
              ((onboard && key == KEY_PROG) || mode == FM_PROM); // [RULE17] [RULE5]
    next_ok = 1'b0;
    next_undef = 1'b0;
    unique case (ACC_KIND)
      KIND_READ: begin
        next_ok = (mode != FM_ROM_OFF) && (phase != PH_ERASE) && (phase != PH_STRAP)
                  && (settle == '0); // [RULE2] [RULE3] [RULE12]
        next_undef = next_ok && plane_sel && ub_over; // [RULE10]
      end
      KIND_PROG: begin
        next_ok = pe_base && (!plane_sel || mode == FM_BOOT || mode == FM_PROM); // [RULE9] [RULE3]
      end
      KIND_ERASE_BLK: begin
        next_ok = pe_base && !plane_sel && (mode != FM_PROM); // [RULE5] [RULE11]
      end
      KIND_ERASE_ALL: begin
        next_ok = pe_base && (!plane_sel || mode == FM_BOOT || mode == FM_PROM); // [RULE5]
      end
    endcase
    next_done = ACC_REQ;
    if (!ACC_REQ) begin
      next_ok = 1'b0;
      next_undef = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ACC_DONE <= 1'b0;
      ACC_OK <= 1'b0;
      ACC_UNDEF <= 1'b0;
      ACC_PLANE <= 1'b0;
      ACC_BLOCK <= 4'h0;
    end else begin
      ACC_DONE <= next_done;
      ACC_OK <= next_ok;
      ACC_UNDEF <= next_undef;
      ACC_PLANE <= plane_sel; // [RULE6]
      ACC_BLOCK <= blk; // [RULE11]
    end
  end

  // bit rate detect: time the low run of a zero byte from the host
  always_comb begin
    next_ab = ab;
    next_ab_cnt = ab_cnt;
    next_baud = BAUD_DIV;
    next_rxd_d = rxd_s;
    unique case (ab)
      AB_IDLE: begin
        next_ab_cnt = '0;
        if (mode == FM_BOOT && rxd_d && !rxd_s) next_ab = AB_COUNT; // [RULE16]
      end
      AB_COUNT: begin
        if (ab_cnt != '1) next_ab_cnt = ab_cnt + 1'b1;
        if (rxd_s) begin
          next_baud = BAUD_W'(({16'h0, ab_cnt} + 32'd1) / BAUD_BITS); // [RULE16]
          next_ab = AB_LOCK;
        end
      end
      AB_LOCK: ;
      default: next_ab = AB_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ab <= AB_IDLE;
      ab_cnt <= '0;
      BAUD_DIV <= '0;
      rxd_d <= 1'b1;
    end else begin
      ab <= next_ab;
      ab_cnt <= next_ab_cnt;
      BAUD_DIV <= next_baud;
      rxd_d <= next_rxd_d;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  a_rom_off_block: assert property (mode == FM_ROM_OFF && ACC_REQ |=> ACC_DONE && !ACC_OK) // [RULE2]
    else $error("access granted in rom invalid mode");
  a_user_no_write: assert property (mode == FM_USER && ACC_REQ && ACC_KIND != KIND_READ |=> !ACC_OK) // [RULE3]
    else $error("program or erase granted in user mode");
  a_user_read_ok: assert property (mode == FM_USER && phase == PH_RUN && settle == '0 && ACC_REQ
    && ACC_KIND == KIND_READ |=> ACC_OK) // [RULE3]
    else $error("read refused in user mode");
  a_prom_no_block: assert property (mode == FM_PROM && ACC_REQ && ACC_KIND == KIND_ERASE_BLK |=> !ACC_OK) // [RULE5]
    else $error("block erase granted in programmer mode");
  a_ub_prog_gate: assert property (ACC_REQ && plane_sel && ACC_KIND == KIND_PROG && mode != FM_BOOT
    && mode != FM_PROM |=> !ACC_OK) // [RULE9]
    else $error("boot plane programmed outside boot or programmer mode");
  a_ub_undef_read: assert property (ACC_REQ && ACC_KIND == KIND_READ && plane_sel && ACC_ADDR >= UB_SIZE
    |=> ACC_UNDEF == ACC_OK) // [RULE10]
    else $error("out of range boot plane read not flagged");
  a_boot_erase_first: assert property (mode == FM_BOOT && phase != PH_RUN && ACC_REQ |=> !ACC_OK) // [RULE12]
    else $error("boot mode access before auto erase");
  a_key_protect: assert property (ACC_REQ && ACC_KIND != KIND_READ && (key != KEY_PROG || !fwe_s)
    && mode != FM_PROM |=> !ACC_OK) // [RULE17]
    else $error("program or erase granted while protected");
  a_pe_switch: assert property (started && mode == FM_USER && pgm_en |=> mode == FM_USER_PROG ##1
    VEC_SRC == VEC_USER) // [RULE15]
    else $error("user program mode not entered");
  a_vec_embedded: assert property (phase == PH_VECTOR && !vec_done_wr |=> VEC_SRC == VEC_EMB) // [RULE8]
    else $error("vector not from embedded storage");
  a_dl_key: assert property ($rose(dl) |-> $past(key) == KEY_DL) // [RULE19]
    else $error("download started without key");
endmodule
`default_nettype wire

// [dv/fmac_cpu_model.sv]
// fmac_cpu_model: cpu-side procedure code that answers one pending request
// assumes the request is a level on the same clock that falls after done
`timescale 1ns/10ps
`default_nettype none
module fmac_cpu_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] lat,
  input wire logic req,
  output logic done = 1'b0
);
  logic [15:0] cnt = 16'h0000;
  // count pending cycles, answer once after lat of them; lat 0 answers at once
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 16'h0000;
      done <= 1'b0;
    end else begin
      done <= req && (cnt == {8'h00, lat});
      cnt <= req ? cnt + 16'h0001 : 16'h0000;
    end
  end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// tb_top: self-checking bench for the flash plane and mode access control
// assumes fmac_pkg, fmac_top and fmac_cpu_model are compiled before it
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import fmac_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] mode_pins = 3'h4;
  logic flash_write_enable_pin = 1'b1;
  logic rxd = 1'b1;
  logic acc_req = 1'b0;
  logic [1:0] acc_kind = 2'h0;
  logic [ADDR_W-1:0] acc_addr = 19'h0;
  logic [7:0] erase_lat = 8'h28;
  logic [7:0] dl_lat = 8'h1e;
  logic pready, pslverr, acc_done, acc_ok, acc_undef, acc_plane, erase_req, dl_req, erase_done, dl_done, rerr;
  logic [31:0] prdata, rdata, rnd;
  logic [3:0] acc_block;
  logic [1:0] vec_src;
  logic [15:0] baud_div;
  logic [2:0] mode_state;
  logic [ADDR_W-1:0] a;
  logic [1:0] expq[$];
  int miscompares = 0;
  int n_tests = 0;
  // granted kinds per pin code, bit k for access kind k
  logic [3:0] tbl [5] = '{4'b0000, 4'b0000, 4'b0001, 4'b1011, 4'b0001};
  logic [2:0] mexp [5] = '{FM_ROM_OFF, FM_BOOT, FM_USER_BOOT, FM_PROM, FM_USER};
  logic [ADDR_W-1:0] bnd [8] = '{19'h00000, 19'h00fff, 19'h01000, 19'h07fff, 19'h08000, 19'h0ffff, 19'h10000,
    19'h7ffff};

  // 20 MHz clock
  always #25 clk = ~clk;

  fmac_top fmac_top_inst (.REF_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .MODE_PINS(mode_pins),
    .FWE_PIN(flash_write_enable_pin), .RXD(rxd), .ACC_REQ(acc_req), .ACC_KIND(acc_kind), .ACC_ADDR(acc_addr), .ACC_DONE(acc_done),
    .ACC_OK(acc_ok), .ACC_UNDEF(acc_undef), .ACC_PLANE(acc_plane), .ACC_BLOCK(acc_block), .VEC_SRC(vec_src),
    .AUTO_ERASE_REQ(erase_req), .AUTO_ERASE_DONE(erase_done), .DL_REQ(dl_req), .DL_DONE(dl_done),
    .BAUD_DIV(baud_div), .MODE_STATE(mode_state));
  fmac_cpu_model erase_agent (.clk(clk), .rst_b(rst_b), .lat(erase_lat), .req(erase_req), .done(erase_done));
  fmac_cpu_model dl_agent (.clk(clk), .rst_b(rst_b), .lat(dl_lat), .req(dl_req), .done(dl_done));

  // bench helpers: random source, block map, compare, verdict
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [3:0] blk_of(input logic [ADDR_W-1:0] x);
    if (x < SMALL_END) return x[15:12];
    if (x < MID_END) return 4'h8;
    return 4'h9 + 4'(x[18:16] - 3'h1);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t ns: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d, notes left %0d", n_tests, miscompares, expq.size());
    if (miscompares == 0 && n_tests > 0 && expq.size() == 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // straps are held through four reset edges and kept three edges after
  task automatic rst(input logic [2:0] p);
    @(posedge clk);
    rst_b <= 1'b0;
    mode_pins <= p;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr = pslverr;
    if (n == 20) miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // access request stays up across calls, so calls run back to back
  task automatic acc(input logic [1:0] k, input logic [ADDR_W-1:0] x, input logic [1:0] e);
    @(posedge clk);
    acc_req <= 1'b1;
    acc_kind <= k;
    acc_addr <= x;
    expq.push_back(e);
  endtask
  task automatic acc_end;
    @(posedge clk);
    acc_req <= 1'b0;
  endtask

  // each answer is matched with the oldest noted expectation
  always @(posedge clk) begin
    if (acc_done === 1'b1) begin
      if (expq.size() == 0)
        chk(32'h1, 32'h0);
      else
        chk(32'({acc_ok, acc_undef}), 32'(expq.pop_front()));
    end
  end

  // give up if the sequence stalls
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report();
  end

  // main sequence
  initial begin
    rnd = 32'h56c3;
    for (int i = 0; i < 5; i++) begin
      rst(3'(i));
      chk(32'(mode_state), 32'(mexp[i]));
      if (i inside {1, 2, 4})
        chk(32'(vec_src), (i == 4) ? 32'(VEC_USER) : 32'(VEC_EMB));
      for (int k = 0; k < 4; k++)
        acc(2'(k), 19'h00080, {tbl[i][k], 1'b0});
      acc_end();
      mode_pins <= 3'(4 - i);
      repeat (6) @(posedge clk);
      chk(32'(mode_state), 32'(mexp[i]));
    end
    tdone("mode table");
    for (int j = 0; j < 20; j++) begin
      rnd = lfsr(rnd);
      a = (j < 8) ? bnd[j] : rnd[ADDR_W-1:0];
      @(posedge clk);
      acc_addr <= a;
      repeat (2) @(posedge clk);
      chk(32'(acc_block), 32'(blk_of(a)));
    end
    tdone("erase blocks");
    rst(3'h4);
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(mode_state), 32'(FM_USER_PROG));
    apb(1'b1, OFS_KEY, 32'(KEY_PROG));
    acc(KIND_PROG, 19'h00100, 2'b10);
    acc(KIND_ERASE_BLK, 19'h10000, 2'b10);
    acc_end();
    flash_write_enable_pin <= 1'b0;
    repeat (4) @(posedge clk);
    acc(KIND_PROG, 19'h00180, 2'b00);
    acc_end();
    flash_write_enable_pin <= 1'b1;
    apb(1'b1, OFS_KEY, 32'(KEY_RESET));
    acc(KIND_PROG, 19'h00200, 2'b00);
    acc_end();
    apb(1'b1, OFS_KEY, 32'(KEY_PROG));
    apb(1'b1, OFS_PLANE, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(acc_plane), 32'h1);
    acc(KIND_PROG, 19'h00000, 2'b00);
    acc(KIND_READ, UB_SIZE, 2'b11);
    acc(KIND_READ, UB_SIZE - 19'h4, 2'b10);
    acc_end();
    apb(1'b1, OFS_PLANE, 32'h0);
    apb(1'b1, OFS_CODE, 32'h1);
    apb(1'b0, OFS_CODE, 32'h0);
    chk(32'(rdata[CODE_DL_BIT]), 32'h0);
    apb(1'b1, OFS_KEY, 32'(KEY_DL));
    apb(1'b1, OFS_CODE, 32'h1);
    apb(1'b0, OFS_CODE, 32'h0);
    chk(32'(rdata[CODE_DL_BIT]), 32'h1);
    repeat (40) @(posedge clk);
    apb(1'b0, OFS_CODE, 32'h0);
    chk(32'(rdata[CODE_DL_BIT]), 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(mode_state), 32'(FM_USER));
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rdata, 32'(FM_USER) | (32'h3 << STAT_PHASE_LSB) | (32'h1 << STAT_SETTLE_BIT));
    acc(KIND_READ, 19'h00000, 2'b00);
    acc(KIND_PROG, 19'h00280, 2'b00);
    acc_end();
    repeat (SETTLE_CYC) @(posedge clk);
    acc(KIND_READ, 19'h00000, 2'b10);
    acc_end();
    apb(1'b1, 8'h1c, 32'hffffffff);
    apb(1'b0, 8'h1c, 32'h0);
    chk({rdata[30:0], rerr}, 32'h1);
    apb(1'b1, OFS_STATUS, 32'hffffffff);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rdata, 32'(FM_USER) | (32'h3 << STAT_PHASE_LSB));
    tdone("user program");
    rst(MP_USER_BOOT);
    apb(1'b1, OFS_CTRL, 32'h1 << CTRL_VEC_DONE_BIT);
    @(posedge clk);
    chk(32'(vec_src), 32'(VEC_UBOOT));
    apb(1'b1, OFS_KEY, 32'(KEY_PROG));
    acc(KIND_PROG, 19'h00300, 2'b10);
    acc_end();
    apb(1'b1, OFS_PLANE, 32'h1);
    acc(KIND_PROG, 19'h00000, 2'b00);
    acc(KIND_ERASE_ALL, 19'h00000, 2'b00);
    acc_end();
    tdone("user boot");
    rst(MP_BOOT);
    chk(32'(erase_req), 32'h1);
    apb(1'b1, OFS_KEY, 32'(KEY_PROG));
    acc(KIND_ERASE_BLK, 19'h08000, 2'b00);
    acc_end();
    rxd <= 1'b0;
    repeat (9 * 12) @(posedge clk);
    rxd <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'(baud_div), 32'd12);
    rxd <= 1'b0;
    repeat (45) @(posedge clk);
    rxd <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'(baud_div), 32'd12);
    chk(32'(erase_req), 32'h0);
    acc(KIND_READ, 19'h00000, 2'b10);
    acc(KIND_ERASE_BLK, 19'h08000, 2'b10);
    acc_end();
    apb(1'b1, OFS_PLANE, 32'h1);
    acc(KIND_PROG, 19'h00080, 2'b10);
    acc_end();
    chk(32'(vec_src), 32'(VEC_EMB));
    tdone("boot");
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule
`default_nettype wire
